//--- src/tpb_top.sv
// Purpose: Timer pin select registers and byte buffer behind an Avalon-MM slave.
// Assumes: 40 MHz clock i_ref_clk; the counter value arrives on the same clock.
// Notes: Each access answers with waitrequest low one cycle after it is taken.
//
// Summary of operation
// - A select bit of one sends the timer signal to its pin, zero withholds it.
// - A selected pin serves the timer as input or output, an unselected one keeps its other use.
// - In the full low layout bit 7 picks enhanced A, bits 6 to 4 the B outputs, bits 1 and 0 compact.
// - In the three-timer high layout only bits 1 and 0 exist, for the standard timer outputs.
// - Select bits that do not exist read as zero and ignore writes.
// - Counter and compare pairs show high bytes directly and low bytes only through one buffer.
// - The buffer and a low byte exchange data only when the matching high byte is accessed.
// - A compare low byte write only loads the buffer and leaves the compare value alone.
// - A compare high byte write stores it and copies the buffer into the low byte together.
// - A high byte read returns it and captures the live low byte into the buffer.
// - A low byte read returns the buffer, not the live low byte.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "tpb_cfg.svh"
module tpb_top import tpb_pkg::*; #(
	parameter tpb_lo_e LO_LAYOUT = TPB_LO_FULL,
	parameter tpb_hi_e HI_LAYOUT = TPB_HI_FOUR,
	parameter int CNT_W = `TPB_CNT_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [`TPB_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [CNT_W-1:0] i_count_value,
	output logic [CNT_W-1:0] o_compare_a_value,
	output logic [CNT_W-1:0] o_compare_b_value,
	input wire logic [`TPB_PIN_N-1:0] i_tmr_out,
	input wire logic [`TPB_PIN_N-1:0] i_alt_out,
	input wire logic [`TPB_PIN_N-1:0] i_pin_in,
	output logic [`TPB_PIN_N-1:0] o_pin_out,
	output logic [`TPB_PIN_N-1:0] o_tmr_in
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam tpb_byte_t LO_MASK = tpb_lo_mask(LO_LAYOUT);
	localparam tpb_byte_t HI_MASK = tpb_hi_mask(HI_LAYOUT);

	typedef struct packed {
		logic [7:0] sel_lo;
		logic [7:0] sel_hi;
		logic wait_q;
		logic [31:0] rdata;
	} tpb_top_s;

	// Only existing select bits take their reset value.
	localparam tpb_top_s RST_STATE = '{
		sel_lo: `TPB_LO_RST & LO_MASK,
		sel_hi: `TPB_HI_RST & HI_MASK,
		wait_q: 1'b1,
		rdata: 32'h0000_0000
	};

	tpb_top_s state_ff;
	tpb_top_s nxt_state;
	tpb_reg_e sel_reg;
	logic take;
	logic wr_ok;

	tpb_link_if link ();

	function automatic tpb_reg_e decode(input logic [`TPB_ADDR_W-1:0] a);
		unique case ({a[`TPB_ADDR_W-1:2], 2'b00})
			`TPB_OFS_ROUTE_LO: return TPB_REG_ROUTE_LO;
			`TPB_OFS_ROUTE_HI: return TPB_REG_ROUTE_HI;
			`TPB_OFS_CMP_A_LO: return TPB_REG_A_LO;
			`TPB_OFS_CMP_A_HI: return TPB_REG_A_HI;
			`TPB_OFS_CMP_B_LO: return TPB_REG_B_LO;
			`TPB_OFS_CMP_B_HI: return TPB_REG_B_HI;
			`TPB_OFS_CNT_LO: return TPB_REG_CNT_LO;
			`TPB_OFS_CNT_HI: return TPB_REG_CNT_HI;
			default: return TPB_REG_NONE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		// A request is taken once; the answer cycle blocks a second take of the same request.
		take = (i_avs_read || i_avs_write) && state_ff.wait_q;
		wr_ok = i_avs_write && i_avs_byteenable[`TPB_BE_LANE0];
		sel_reg = decode(i_avs_address);
		nxt_state.wait_q = !take;
		link.acc_rd = 1'b0;
		link.acc_wr = 1'b0;
		link.acc_hi = 1'b0;
		link.acc_pair = TPB_PAIR_A;
		link.acc_wdata = i_avs_writedata[7:0];
		if (take) begin
			unique case (sel_reg)
				TPB_REG_A_LO, TPB_REG_A_HI: link.acc_pair = TPB_PAIR_A;
				TPB_REG_B_LO, TPB_REG_B_HI: link.acc_pair = TPB_PAIR_B;
				TPB_REG_CNT_LO, TPB_REG_CNT_HI: link.acc_pair = TPB_PAIR_CNT;
				TPB_REG_ROUTE_LO, TPB_REG_ROUTE_HI, TPB_REG_NONE: link.acc_pair = TPB_PAIR_A;
			endcase
			link.acc_hi = sel_reg inside {TPB_REG_A_HI, TPB_REG_B_HI, TPB_REG_CNT_HI};
			if (sel_reg inside {TPB_REG_A_LO, TPB_REG_A_HI, TPB_REG_B_LO, TPB_REG_B_HI,
				TPB_REG_CNT_LO, TPB_REG_CNT_HI}) begin
				link.acc_rd = i_avs_read;
				link.acc_wr = wr_ok;
			end
			if (i_avs_read) begin
				unique case (sel_reg)
					TPB_REG_ROUTE_LO: nxt_state.rdata = {24'h00_0000, state_ff.sel_lo};
					TPB_REG_ROUTE_HI: nxt_state.rdata = {24'h00_0000, state_ff.sel_hi};
					TPB_REG_NONE: nxt_state.rdata = 32'h0000_0000;
					default: nxt_state.rdata = {24'h00_0000, link.acc_rdata};
				endcase
			end
			if (wr_ok && sel_reg == TPB_REG_ROUTE_LO) begin
				nxt_state.sel_lo = i_avs_writedata[7:0] & LO_MASK;
			end
			if (wr_ok && sel_reg == TPB_REG_ROUTE_HI) begin
				nxt_state.sel_hi = i_avs_writedata[7:0] & HI_MASK;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= RST_STATE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign link.sel_lo = state_ff.sel_lo;
	assign link.sel_hi = state_ff.sel_hi;
	assign o_avs_readdata = state_ff.rdata;
	assign o_avs_waitrequest = state_ff.wait_q;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	tpb_pin_route u_route (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.link(link.route),
		.i_tmr_out(i_tmr_out),
		.i_alt_out(i_alt_out),
		.i_pin_in(i_pin_in),
		.o_pin_out(o_pin_out),
		.o_tmr_in(o_tmr_in)
	);

	// Access order is left to software; a wrong order simply moves stale bytes.
	tpb_byte_buf #(.CNT_W(CNT_W)) u_buf (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.link(link.buffer),
		.i_count_value(i_count_value),
		.o_compare_a_value(o_compare_a_value),
		.o_compare_b_value(o_compare_b_value)
	);
endmodule

//--- src/tpb_cfg.svh
// Purpose: Offsets, masks, reset values and sizes of the timer pin select and byte buffer block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register.
// Notes: Masks mark the select bits that exist in each register layout.
`ifndef TPB_CFG_SVH
`define TPB_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TPB_ADDR_W 6
`define TPB_OFS_ROUTE_LO 6'h00
`define TPB_OFS_ROUTE_HI 6'h04
`define TPB_OFS_CMP_A_LO 6'h08
`define TPB_OFS_CMP_A_HI 6'h0C
`define TPB_OFS_CMP_B_LO 6'h10
`define TPB_OFS_CMP_B_HI 6'h14
`define TPB_OFS_CNT_LO 6'h18
`define TPB_OFS_CNT_HI 6'h1C

// ----------------------------------------------------------------
// Select bit layouts and reset values
// ----------------------------------------------------------------
`define TPB_LO_MASK_SMALL 8'h31
`define TPB_LO_MASK_MID 8'hB3
`define TPB_LO_MASK_FULL 8'hF3
`define TPB_HI_MASK_NONE 8'h00
`define TPB_HI_MASK_THREE 8'h03
`define TPB_HI_MASK_FOUR 8'h33
`define TPB_LO_RST 8'h91
`define TPB_HI_RST 8'h11

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TPB_PIN_N 16
`define TPB_CNT_W 10
`define TPB_BE_LANE0 0

`endif

//--- src/tpb_pkg.sv
// Purpose: Types and layout decoding shared by the block's modules.
// Assumes: The constants header is compiled first.
// Notes: Layout enums choose which select bits exist.
`include "tpb_cfg.svh"
package tpb_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TPB_LO_SMALL = 2'h0, TPB_LO_MID = 2'h1, TPB_LO_FULL = 2'h3} tpb_lo_e;
	typedef enum logic [1:0] {TPB_HI_NONE = 2'h0, TPB_HI_THREE = 2'h1, TPB_HI_FOUR = 2'h3} tpb_hi_e;
	typedef enum logic [1:0] {TPB_PAIR_A = 2'h0, TPB_PAIR_B = 2'h1, TPB_PAIR_CNT = 2'h3} tpb_pair_e;
	typedef enum logic [3:0] {
		TPB_REG_ROUTE_LO, TPB_REG_ROUTE_HI, TPB_REG_A_LO, TPB_REG_A_HI,
		TPB_REG_B_LO, TPB_REG_B_HI, TPB_REG_CNT_LO, TPB_REG_CNT_HI, TPB_REG_NONE
	} tpb_reg_e;
	typedef logic [7:0] tpb_byte_t;

	// ----------------------------------------------------------------
	// Layout masks
	// ----------------------------------------------------------------
	function automatic tpb_byte_t tpb_lo_mask(input tpb_lo_e lay);
		unique case (lay)
			TPB_LO_SMALL: return `TPB_LO_MASK_SMALL;
			TPB_LO_MID: return `TPB_LO_MASK_MID;
			TPB_LO_FULL: return `TPB_LO_MASK_FULL;
		endcase
	endfunction

	function automatic tpb_byte_t tpb_hi_mask(input tpb_hi_e lay);
		unique case (lay)
			TPB_HI_NONE: return `TPB_HI_MASK_NONE;
			TPB_HI_THREE: return `TPB_HI_MASK_THREE;
			TPB_HI_FOUR: return `TPB_HI_MASK_FOUR;
		endcase
	endfunction

endpackage

//--- src/tpb_link_if.sv
// Purpose: Carries select bits and byte access strobes between the block's modules.
// Assumes: One clock; strobes last one cycle.
// Notes: The read byte answers combinationally in the strobe's cycle.
`timescale 1ns/1ps
interface tpb_link_if import tpb_pkg::*; ();
	logic [7:0] sel_lo;
	logic [7:0] sel_hi;
	logic acc_rd;
	logic acc_wr;
	logic acc_hi;
	tpb_pair_e acc_pair;
	tpb_byte_t acc_wdata;
	tpb_byte_t acc_rdata;

	modport ctl (output sel_lo, sel_hi, acc_rd, acc_wr, acc_hi, acc_pair, acc_wdata,
		input acc_rdata);
	modport route (input sel_lo, sel_hi);
	modport buffer (input acc_rd, acc_wr, acc_hi, acc_pair, acc_wdata, output acc_rdata);
endinterface

//--- src/tpb_pin_route.sv
// Purpose: Steers each shared pin between timer and its other function.
// Assumes: Pin inputs are asynchronous; timer and alternate outputs share the clock.
// Notes: Pin index 0 to 7 follows the low select register, 8 to 15 the high one.
`timescale 1ns/1ps
module tpb_pin_route import tpb_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_n,
	tpb_link_if.route link,
	input wire logic [`TPB_PIN_N-1:0] i_tmr_out,
	input wire logic [`TPB_PIN_N-1:0] i_alt_out,
	input wire logic [`TPB_PIN_N-1:0] i_pin_in,
	output logic [`TPB_PIN_N-1:0] o_pin_out,
	output logic [`TPB_PIN_N-1:0] o_tmr_in
);
	typedef struct packed {
		logic [`TPB_PIN_N-1:0] s1;
		logic [`TPB_PIN_N-1:0] s2;
		logic [`TPB_PIN_N-1:0] s3;
		logic [`TPB_PIN_N-1:0] level;
		logic [`TPB_PIN_N-1:0] pin_out;
		logic [`TPB_PIN_N-1:0] tmr_in;
	} tpb_route_s;

	tpb_route_s state_ff;
	tpb_route_s nxt_state;
	logic [`TPB_PIN_N-1:0] sel;

	always_comb begin
		sel = {link.sel_hi, link.sel_lo};
		nxt_state = state_ff;
		nxt_state.s1 = i_pin_in;
		nxt_state.s2 = state_ff.s1;
		nxt_state.s3 = state_ff.s2;
		// A pin level is believed only once two later stages agree.
		nxt_state.level = (state_ff.s2 & state_ff.s3) | (state_ff.level & (state_ff.s2 | state_ff.s3));
		nxt_state.pin_out = (sel & i_tmr_out) | (~sel & i_alt_out);
		nxt_state.tmr_in = sel & state_ff.level;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_pin_out = state_ff.pin_out;
	assign o_tmr_in = state_ff.tmr_in;
endmodule

//--- src/tpb_byte_buf.sv
// Purpose: Shared 8-bit holding buffer for the counter and compare register pairs.
// Assumes: Strobes are single-cycle and never read and write together.
// Notes: The counter pair is read only; writes to it are dropped.
`timescale 1ns/1ps
module tpb_byte_buf import tpb_pkg::*; #(
	parameter int CNT_W = `TPB_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	tpb_link_if.buffer link,
	input wire logic [CNT_W-1:0] i_count_value,
	output logic [CNT_W-1:0] o_compare_a_value,
	output logic [CNT_W-1:0] o_compare_b_value
);
	if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
		$error("Counter width must lie between 9 and 16 bits.");
	end

	localparam int HW = CNT_W - 8;

	typedef struct packed {
		logic [7:0] hold;
		logic [CNT_W-1:0] cmp_a;
		logic [CNT_W-1:0] cmp_b;
	} tpb_buf_s;

	tpb_buf_s state_ff;
	tpb_buf_s nxt_state;
	logic [CNT_W-1:0] pair_now;

	function automatic logic [CNT_W-1:0] pair_val(input tpb_pair_e p, input tpb_buf_s s,
		input logic [CNT_W-1:0] cnt);
		unique case (p)
			TPB_PAIR_A: return s.cmp_a;
			TPB_PAIR_B: return s.cmp_b;
			TPB_PAIR_CNT: return cnt;
		endcase
	endfunction

	always_comb begin
		nxt_state = state_ff;
		pair_now = pair_val(link.acc_pair, state_ff, i_count_value);
		// Only the high byte sits on the bus directly; the low byte goes via the buffer.
		if (link.acc_hi) begin
			link.acc_rdata = 8'(pair_now >> 8);
		end else begin
			link.acc_rdata = state_ff.hold;
		end
		if (link.acc_rd && link.acc_hi) begin
			nxt_state.hold = pair_now[7:0];
		end
		if (link.acc_wr && link.acc_pair != TPB_PAIR_CNT) begin
			if (!link.acc_hi) begin
				nxt_state.hold = link.acc_wdata;
			end else if (link.acc_pair == TPB_PAIR_A) begin
				nxt_state.cmp_a = {link.acc_wdata[HW-1:0], state_ff.hold};
			end else begin
				nxt_state.cmp_b = {link.acc_wdata[HW-1:0], state_ff.hold};
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_compare_a_value = state_ff.cmp_a;
	assign o_compare_b_value = state_ff.cmp_b;
endmodule

//--- testbench/tpb_props.sv
// Purpose: Port level checks of the timer pin select and byte buffer block.
// Assumes: Only top ports are visible; compare and count offsets as in the constants header.
// Notes: Checks wait a few edges after reset, because the block lifts its reset late.
`timescale 1ns/1ps
`include "tpb_cfg.svh"
module tpb_props #(
	parameter int CNT_W = `TPB_CNT_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [`TPB_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [CNT_W-1:0] i_count_value,
	input wire logic [CNT_W-1:0] o_compare_a_value,
	input wire logic [CNT_W-1:0] o_compare_b_value,
	input wire logic [`TPB_PIN_N-1:0] i_tmr_out,
	input wire logic [`TPB_PIN_N-1:0] i_alt_out,
	input wire logic [`TPB_PIN_N-1:0] o_pin_out
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic [2:0] live_cnt_ff;
	logic live;
	logic take;
	logic wr_a_hi;
	logic wr_b_hi;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			live_cnt_ff <= 3'h0;
		end else if (live_cnt_ff != 3'h7) begin
			live_cnt_ff <= live_cnt_ff + 3'h1;
		end
	end
	assign live = (live_cnt_ff == 3'h7);
	assign take = (i_avs_read | i_avs_write) & o_avs_waitrequest;
	assign wr_a_hi = take & i_avs_write & i_avs_byteenable[0]
		& ((i_avs_address & 6'h3C) == `TPB_OFS_CMP_A_HI);
	assign wr_b_hi = take & i_avs_write & i_avs_byteenable[0]
		& ((i_avs_address & 6'h3C) == `TPB_OFS_CMP_B_HI);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!live);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_wait_answer: assert property (take |=> !o_avs_waitrequest)
		else $error("request not answered in one cycle");
	a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("answer lasted more than one cycle");
	a_upper_zero: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property (take && i_avs_read && i_avs_address >= 6'h20
		|=> o_avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	a_pin_agree: assert property (((o_pin_out ^ $past(i_alt_out))
		& ~($past(i_tmr_out) ^ $past(i_alt_out))) == '0) else $error("pin level wrong");
	a_cmpa_hold: assert property ($changed(o_compare_a_value) |-> $past(wr_a_hi))
		else $error("compare a moved without high write");
	a_cmpb_hold: assert property ($changed(o_compare_b_value) |-> $past(wr_b_hi))
		else $error("compare b moved without high write");
	a_cmpa_high: assert property (wr_a_hi |=>
		o_compare_a_value[CNT_W-1:8] == $past(i_avs_writedata[CNT_W-9:0]))
		else $error("compare a high bits wrong");
	a_count_high: assert property (take && i_avs_read
		&& (i_avs_address & 6'h3C) == `TPB_OFS_CNT_HI
		|=> o_avs_readdata[CNT_W-9:0] == $past(i_count_value[CNT_W-1:8]))
		else $error("count high read wrong");
	c_cmp_write: cover property (wr_a_hi);
	c_cmp_b_write: cover property (wr_b_hi);
	c_unmapped: cover property (take && i_avs_read && i_avs_address >= 6'h20);
endmodule

bind tpb_top tpb_props #(.CNT_W(CNT_W)) i_props (.i_ref_clk, .i_rstn, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
	.o_avs_waitrequest, .i_count_value, .o_compare_a_value, .o_compare_b_value,
	.i_tmr_out, .i_alt_out, .o_pin_out);

//--- testbench/timer_pin_select_byte_buffer_test.sv
// Purpose: Self checking bench of the timer pin select and byte buffer block.
// Assumes: Full low layout, four timer high layout, 10 bit pairs.
// Notes: Reads note their expected byte in a queue; a watcher compares on each answer.
`timescale 1ns/1ps
`include "tpb_cfg.svh"
module timer_pin_select_byte_buffer_test;
	localparam int CW = 10;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [5:0] i_avs_address = 6'h00;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0000_0000;
	logic [3:0] i_avs_byteenable = 4'h1;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic [CW-1:0] i_count_value = '0;
	logic [CW-1:0] o_compare_a_value;
	logic [CW-1:0] o_compare_b_value;
	logic [15:0] i_tmr_out = 16'h0000;
	logic [15:0] i_alt_out = 16'h0000;
	logic [15:0] i_pin_in = 16'h0000;
	logic [15:0] o_pin_out;
	logic [15:0] o_tmr_in;
	logic [31:0] rd_three;
	int errors = 0;
	int compares = 0;
	int seed = 30;
	int cyc = 0;
	logic [31:0] expq[$];
	logic [7:0] sl, sh, d, h;
	logic [CW-1:0] v, got;
	logic [CW-1:0] cmp[2] = '{'0, '0};
	logic [5:0] base;

	always #12.5 i_ref_clk = ~i_ref_clk;

	tpb_top #(.CNT_W(CW)) i_dut (.i_ref_clk, .i_rstn, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
		.o_avs_waitrequest, .i_count_value, .o_compare_a_value, .o_compare_b_value,
		.i_tmr_out, .i_alt_out, .i_pin_in, .o_pin_out, .o_tmr_in);

	// A second copy in the mid low and three-timer high layouts shares the bus stimulus.
	tpb_top #(.LO_LAYOUT(tpb_pkg::TPB_LO_MID), .HI_LAYOUT(tpb_pkg::TPB_HI_THREE),
		.CNT_W(CW)) i_dut_three (.i_ref_clk, .i_rstn, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata(rd_three),
		.o_avs_waitrequest(), .i_count_value, .o_compare_a_value(), .o_compare_b_value(),
		.i_tmr_out, .i_alt_out, .i_pin_in, .o_pin_out(), .o_tmr_in());

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Low address bits are ignored by the slave, so they are stirred at random.
	task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] dat,
		input logic [31:0] e);
		logic [31:0] r;
		r = $random(seed);
		@(posedge i_ref_clk);
		i_avs_address <= a | {4'h0, r[1:0]};
		i_avs_read <= ~wr;
		i_avs_write <= wr;
		i_avs_writedata <= {r[31:8], dat};
		if (!wr) expq.push_back(e);
		do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task automatic pins();
		logic [15:0] sel;
		sel = {sh & `TPB_HI_MASK_FOUR, sl & `TPB_LO_MASK_FULL};
		@(posedge i_ref_clk);
		i_tmr_out <= 16'($random(seed));
		i_alt_out <= 16'($random(seed));
		i_pin_in <= 16'($random(seed));
		repeat (8) @(posedge i_ref_clk);
		check({16'h0000, o_pin_out}, {16'h0000, (sel & i_tmr_out) | (~sel & i_alt_out)});
		check({16'h0000, o_tmr_in}, {16'h0000, sel & i_pin_in});
	endtask

	// ----------------------------------------------------------------
	// Watcher and timeout
	// ----------------------------------------------------------------
	always @(posedge i_ref_clk) begin
		if (o_avs_waitrequest === 1'b0 && i_avs_read === 1'b1 && expq.size() > 0) begin
			check(o_avs_readdata, expq.pop_front());
		end
	end

	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		acc(0, `TPB_OFS_ROUTE_LO, 8'h00, {24'h00_0000, `TPB_LO_RST});
		check(rd_three, {24'h00_0000, `TPB_LO_RST & `TPB_LO_MASK_MID});
		acc(0, `TPB_OFS_ROUTE_HI, 8'h00, {24'h00_0000, `TPB_HI_RST});
		check(rd_three, {24'h00_0000, `TPB_HI_RST & `TPB_HI_MASK_THREE});
		sl = `TPB_LO_RST;
		sh = `TPB_HI_RST;
		pins();
		i_avs_byteenable <= 4'h0;
		acc(1, `TPB_OFS_ROUTE_LO, 8'h00, 32'h0000_0000);
		i_avs_byteenable <= 4'h1;
		acc(0, `TPB_OFS_ROUTE_LO, 8'h00, {24'h00_0000, `TPB_LO_RST});
		for (int i = 0; i < 6; i++) begin
			sl = (i == 0) ? 8'hFF : 8'($random(seed));
			sh = (i == 0) ? 8'hFF : 8'($random(seed));
			acc(1, `TPB_OFS_ROUTE_LO, sl, 32'h0000_0000);
			acc(1, `TPB_OFS_ROUTE_HI, sh, 32'h0000_0000);
			acc(0, `TPB_OFS_ROUTE_LO, 8'h00, {24'h00_0000, sl & `TPB_LO_MASK_FULL});
			check(rd_three, {24'h00_0000, sl & `TPB_LO_MASK_MID});
			acc(0, `TPB_OFS_ROUTE_HI, 8'h00, {24'h00_0000, sh & `TPB_HI_MASK_FOUR});
			check(rd_three, {24'h00_0000, sh & `TPB_HI_MASK_THREE});
			pins();
		end
		for (int i = 0; i < 8; i++) begin
			base = (i % 2) ? `TPB_OFS_CMP_B_LO : `TPB_OFS_CMP_A_LO;
			d = 8'($random(seed));
			h = 8'($random(seed));
			acc(1, base, d, 32'h0000_0000);
			got = (i % 2) ? o_compare_b_value : o_compare_a_value;
			check(32'(got), 32'(cmp[i%2]));
			acc(1, base + 6'h04, h, 32'h0000_0000);
			cmp[i%2] = {h[CW-9:0], d};
			got = (i % 2) ? o_compare_b_value : o_compare_a_value;
			check(32'(got), 32'(cmp[i%2]));
			acc(0, base + 6'h04, 8'h00, 32'(h[CW-9:0]));
			acc(0, base, 8'h00, 32'(d));
		end
		for (int i = 0; i < 4; i++) begin
			v = CW'($random(seed));
			d = 8'($random(seed));
			i_count_value <= v;
			acc(1, `TPB_OFS_CMP_A_LO, d, 32'h0000_0000);
			acc(0, `TPB_OFS_CNT_LO, 8'h00, 32'(d));
			acc(1, `TPB_OFS_CNT_HI, 8'hFF, 32'h0000_0000);
			acc(0, `TPB_OFS_CNT_HI, 8'h00, 32'(v[CW-1:8]));
			i_count_value <= ~v;
			acc(0, `TPB_OFS_CNT_LO, 8'h00, 32'(v[7:0]));
		end
		acc(1, 6'h20, 8'hFF, 32'h0000_0000);
		acc(0, 6'h24, 8'h00, 32'h0000_0000);
		check(32'(o_compare_a_value), 32'(cmp[0]));
		repeat (4) @(posedge i_ref_clk);
		finish_test();
	end
endmodule
